// ==== rtl/rsrx_map.svh ====
// rsrx_map.svh: opcodes, flag bit positions, reset values and cycle counts
// assumes: included by bare name from the execution slice design files
`ifndef RSRX_MAP_SVH
`define RSRX_MAP_SVH

// opcodes handled by this slice
`define RSRX_OP_CLR_CARRY 8'hCF
`define RSRX_OP_RETURN 8'hAF
`define RSRX_OP_RL_R 8'h90
`define RSRX_OP_RL_IR 8'h91
`define RSRX_OP_RLC_R 8'h10
`define RSRX_OP_RLC_IR 8'h11
`define RSRX_OP_RR_R 8'hE0
`define RSRX_OP_RR_IR 8'hF1
`define RSRX_OP_RRC_R 8'hC0
`define RSRX_OP_RRC_IR 8'hC1
`define RSRX_OP_BANK0 8'h4F
`define RSRX_OP_BANK1 8'h5F
`define RSRX_OP_SBC_RR 8'h32
`define RSRX_OP_SBC_RIR 8'h33
`define RSRX_OP_SBC_GG 8'h34
`define RSRX_OP_SBC_GIG 8'h35
`define RSRX_OP_SBC_GIM 8'h36

// bit positions in the flags register
`define RSRX_FLAG_C 7
`define RSRX_FLAG_Z 6
`define RSRX_FLAG_S 5
`define RSRX_FLAG_V 4
`define RSRX_FLAG_D 3
`define RSRX_FLAG_H 2
`define RSRX_FLAG_BANK 0

// reset values
`define RSRX_FLAGS_RST 8'h00
`define RSRX_PC_RST 16'h0000
`define RSRX_SP_RST 16'h0000

// instruction lengths in cpu clock cycles
`define RSRX_CYC_SHORT 4'h4
`define RSRX_CYC_LONG 4'h6
`define RSRX_CYC_RET 4'h8

`endif

// ==== rtl/rsrx_pkg.sv ====
// rsrx_pkg: types of the rotate, subtract and return execution slice
// assumes: compiled before every other file of the slice
package rsrx_pkg;

   // sequencer states, gray along the read path
   typedef enum logic [2:0] {
      RSRX_ST_IDLE = 3'h0,
      RSRX_ST_SPTR = 3'h1,
      RSRX_ST_SRD = 3'h3,
      RSRX_ST_DPTR = 3'h2,
      RSRX_ST_DRD = 3'h6,
      RSRX_ST_EXEC = 3'h7,
      RSRX_ST_HOLD = 3'h5
   } rsrx_state_e_t;

   // what the register file read issued last cycle returns now
   typedef enum logic [2:0] {
      RSRX_P_NONE = 3'h0,
      RSRX_P_SPTR = 3'h1,
      RSRX_P_SRC = 3'h2,
      RSRX_P_DPTR = 3'h3,
      RSRX_P_DST = 3'h4
   } rsrx_pend_t;

   // operation classes
   typedef enum logic [3:0] {
      RSRX_K_CCF = 4'h0,
      RSRX_K_RET = 4'h1,
      RSRX_K_RL = 4'h2,
      RSRX_K_RLC = 4'h3,
      RSRX_K_RR = 4'h4,
      RSRX_K_RRC = 4'h5,
      RSRX_K_SB0 = 4'h6,
      RSRX_K_SB1 = 4'h7,
      RSRX_K_SBC = 4'h8
   } rsrx_kind_t;

   // whole state of the execution core
   typedef struct packed {
      rsrx_state_e_t st;
      rsrx_pend_t pend;
      rsrx_kind_t kind;
      logic src_ind;
      logic dst_ind;
      logic [7:0] src_addr;
      logic [7:0] dst_addr;
      logic [7:0] src_val;
      logic [7:0] dst_val;
      logic [3:0] cnt;
      logic [3:0] ncyc;
      logic [7:0] flags;
      logic [15:0] pc;
      logic [15:0] sp;
      logic busy;
      logic done;
      logic illegal;
   } rsrx_core_t;

endpackage

// ==== rtl/rsrx_mem_if.sv ====
// rsrx_mem_if: register file port between the core and its memory
// assumes: both ends on the same cpu clock
`timescale 1ns/1ps
interface rsrx_mem_if #(parameter int AW = 8, parameter int DW = 8);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   logic [AW-1:0] dbg_addr;
   logic [DW-1:0] dbg_data;

   modport core (output we, waddr, wdata, raddr, dbg_addr,
      input rdata, dbg_data);
   modport mem (input we, waddr, wdata, raddr, dbg_addr,
      output rdata, dbg_data);
endinterface

// ==== rtl/rsrx_regfile.sv ====
// rsrx_regfile: register file, one write port and two registered reads
// assumes: read data appear one clock after the address
`timescale 1ns/1ps
module rsrx_regfile import rsrx_pkg::*; #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   rsrx_mem_if.mem mem
);
   typedef struct packed {
      logic [DW-1:0] rd;
      logic [DW-1:0] dbg;
   } rsrx_rd_t;

   logic [DW-1:0] store [0:(1<<AW)-1];
   rsrx_rd_t r_reg;
   rsrx_rd_t r_next;

   // storage array, written on the write strobe
   always_ff @(posedge i_ref_clk) begin
      if (mem.we) begin
         store[mem.waddr] <= mem.wdata;
      end
   end

   // read ports look up the array
   always_comb begin
      r_next = r_reg;
      r_next.rd = store[mem.raddr];
      r_next.dbg = store[mem.dbg_addr];
   end

   // read data registers
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign mem.rdata = r_reg.rd;
   assign mem.dbg_data = r_reg.dbg;
endmodule

// ==== rtl/rsrx_exec_top.sv ====
// rsrx_exec_top: executes carry clear, return, rotates, bank select, sbc
// assumes: all inputs come from logic on i_ref_clk; operands live in the
// internal register file, stack bytes too
//
// Summary of operation
// - opcode CF clears carry only, other flags kept, 4 cycles
// - opcode AF loads pc from stack, sp plus 2, no flags, 8 cycles
// - lower stack byte is pc high, next byte pc low
// - rotate left: bit 7 to bit 0 and carry; 90/91, 4 cycles
// - rotate left sets overflow on sign change; D and H kept
// - rotate left through carry: old carry in bit 0; 10/11
// - other rotates: overflow when sign bit changes; D and H kept
// - all rotates: zero on zero result, sign copies result bit 7
// - rotate right: bit 0 to bit 7 and carry; E0, indirect F1
// - rotate right through carry: old carry to bit 7; C0/C1
// - opcode 4F clears flags bit 0, bank 0, 4 cycles
// - opcode 5F sets flags bit 0, bank 1, 4 cycles
// - sbc: dst minus src minus carry into dst, src kept
// - sbc forms 32 and 33 two bytes, 34 35 36 three bytes
// - sbc carry on borrow, zero on zero, sign on negative
// - sbc overflow: opposite signs, result sign equals source sign
// - sbc sets D; H set on low nibble borrow, cleared on carry
`timescale 1ns/1ps
`include "rsrx_map.svh"
module rsrx_exec_top import rsrx_pkg::*; #(
   parameter int AW = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_start,
   input wire logic [7:0] i_opcode,
   input wire logic [7:0] i_byte1,
   input wire logic [7:0] i_byte2,
   input wire logic [7:0] i_work_base,
   input wire logic i_ctx_load,
   input wire logic [15:0] i_ctx_pc,
   input wire logic [15:0] i_ctx_sp,
   input wire logic [7:0] i_ctx_flags,
   input wire logic i_load_en,
   input wire logic [AW-1:0] i_load_addr,
   input wire logic [7:0] i_load_data,
   input wire logic [AW-1:0] i_dbg_addr,
   output logic [7:0] o_dbg_data,
   output logic [7:0] o_flags,
   output logic [15:0] o_pc,
   output logic [15:0] o_sp,
   output logic o_busy,
   output logic o_done,
   output logic o_illegal
);
   rsrx_core_t r_reg;
   rsrx_core_t r_next;
   rsrx_mem_if #(.AW(AW), .DW(8)) mem_bus ();
   logic [7:0] cur_dst;
   logic [7:0] fl;
   logic [7:0] res;
   logic [8:0] sub9;
   logic [4:0] low5;
   logic is_rot;

   rsrx_regfile #(.AW(AW), .DW(8)) u_regfile (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .mem(mem_bus.mem)
   );

   // working register n sits in the block picked by the base
   function automatic logic [7:0] work_addr(input logic [7:0] base,
      input logic [3:0] nib);
      work_addr = {base[7:4], nib};
   endfunction

   // next state: decode, operand reads, execution, cycle padding
   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      r_next.illegal = 1'b0;
      r_next.pend = RSRX_P_NONE;
      mem_bus.we = 1'b0;
      mem_bus.waddr = r_reg.dst_addr[AW-1:0];
      mem_bus.wdata = 8'h00;
      mem_bus.raddr = r_reg.src_addr[AW-1:0];
      mem_bus.dbg_addr = i_dbg_addr;
      cur_dst = (r_reg.pend == RSRX_P_DST) ? mem_bus.rdata : r_reg.dst_val;
      fl = r_reg.flags;
      res = 8'h00;
      sub9 = 9'h000;
      low5 = 5'h00;
      is_rot = 1'b0;
      // capture the byte the previous read returned
      case (r_reg.pend)
         RSRX_P_SPTR: r_next.src_addr = mem_bus.rdata;
         RSRX_P_SRC: r_next.src_val = mem_bus.rdata;
         RSRX_P_DPTR: r_next.dst_addr = mem_bus.rdata;
         RSRX_P_DST: r_next.dst_val = mem_bus.rdata;
         default: ;
      endcase
      if (r_reg.st != RSRX_ST_IDLE) begin
         r_next.cnt = r_reg.cnt + 4'h1;
      end
      case (r_reg.st)
         RSRX_ST_IDLE: begin
            // preload from the cpu side while idle
            if (i_load_en) begin
               mem_bus.we = 1'b1;
               mem_bus.waddr = i_load_addr;
               mem_bus.wdata = i_load_data;
            end
            if (i_ctx_load) begin
               r_next.pc = i_ctx_pc;
               r_next.sp = i_ctx_sp;
               r_next.flags = i_ctx_flags;
            end else if (i_start) begin
               r_next.busy = 1'b1;
               r_next.cnt = 4'h1;
               r_next.ncyc = `RSRX_CYC_SHORT;
               r_next.src_ind = 1'b0;
               r_next.dst_ind = i_opcode[0];
               r_next.src_addr = i_byte1;
               r_next.dst_addr = i_byte1;
               r_next.src_val = 8'h00;
               r_next.st = RSRX_ST_DRD;
               case (i_opcode)
                  `RSRX_OP_CLR_CARRY: begin
                     r_next.kind = RSRX_K_CCF;
                     r_next.st = RSRX_ST_EXEC;
                  end
                  `RSRX_OP_BANK0: begin
                     r_next.kind = RSRX_K_SB0;
                     r_next.st = RSRX_ST_EXEC;
                  end
                  `RSRX_OP_BANK1: begin
                     r_next.kind = RSRX_K_SB1;
                     r_next.st = RSRX_ST_EXEC;
                  end
                  `RSRX_OP_RETURN: begin
                     r_next.kind = RSRX_K_RET;
                     r_next.ncyc = `RSRX_CYC_RET;
                     r_next.dst_ind = 1'b0;
                     r_next.src_addr = r_reg.sp[7:0];
                     r_next.dst_addr = r_reg.sp[7:0] + 8'h01;
                     r_next.st = RSRX_ST_SRD;
                  end
                  `RSRX_OP_RL_R, `RSRX_OP_RL_IR: r_next.kind = RSRX_K_RL;
                  `RSRX_OP_RLC_R, `RSRX_OP_RLC_IR: r_next.kind = RSRX_K_RLC;
                  `RSRX_OP_RR_R, `RSRX_OP_RR_IR: r_next.kind = RSRX_K_RR;
                  `RSRX_OP_RRC_R, `RSRX_OP_RRC_IR: r_next.kind = RSRX_K_RRC;
                  `RSRX_OP_SBC_RR, `RSRX_OP_SBC_RIR: begin
                     r_next.kind = RSRX_K_SBC;
                     r_next.dst_ind = 1'b0;
                     r_next.src_ind = i_opcode[0];
                     r_next.ncyc = i_opcode[0] ? `RSRX_CYC_LONG :
                        `RSRX_CYC_SHORT;
                     r_next.src_addr = work_addr(i_work_base, i_byte1[3:0]);
                     r_next.dst_addr = work_addr(i_work_base, i_byte1[7:4]);
                     r_next.st = i_opcode[0] ? RSRX_ST_SPTR : RSRX_ST_SRD;
                  end
                  // sbc full register, source byte first
                  `RSRX_OP_SBC_GG, `RSRX_OP_SBC_GIG: begin
                     r_next.kind = RSRX_K_SBC;
                     r_next.dst_ind = 1'b0;
                     r_next.src_ind = i_opcode[0];
                     r_next.ncyc = `RSRX_CYC_LONG;
                     r_next.dst_addr = i_byte2;
                     r_next.st = i_opcode[0] ? RSRX_ST_SPTR : RSRX_ST_SRD;
                  end
                  `RSRX_OP_SBC_GIM: begin
                     r_next.kind = RSRX_K_SBC;
                     r_next.dst_ind = 1'b0;
                     r_next.ncyc = `RSRX_CYC_LONG;
                     r_next.src_val = i_byte2;
                  end
                  default: begin
                     r_next.busy = 1'b0;
                     r_next.illegal = 1'b1;
                     r_next.st = RSRX_ST_IDLE;
                  end
               endcase
               if (r_next.st == RSRX_ST_DRD && r_next.dst_ind) begin
                  r_next.st = RSRX_ST_DPTR;
               end
            end
         end
         RSRX_ST_SPTR: begin
            r_next.pend = RSRX_P_SPTR;
            r_next.st = RSRX_ST_SRD;
         end
         RSRX_ST_SRD: begin
            if (r_reg.pend == RSRX_P_SPTR) begin
               mem_bus.raddr = mem_bus.rdata[AW-1:0];
            end
            r_next.pend = RSRX_P_SRC;
            r_next.st = r_reg.dst_ind ? RSRX_ST_DPTR : RSRX_ST_DRD;
         end
         RSRX_ST_DPTR: begin
            mem_bus.raddr = r_reg.dst_addr[AW-1:0];
            r_next.pend = RSRX_P_DPTR;
            r_next.st = RSRX_ST_DRD;
         end
         RSRX_ST_DRD: begin
            mem_bus.raddr = (r_reg.pend == RSRX_P_DPTR) ?
               mem_bus.rdata[AW-1:0] : r_reg.dst_addr[AW-1:0];
            r_next.pend = RSRX_P_DST;
            r_next.st = RSRX_ST_EXEC;
         end
         RSRX_ST_EXEC: begin
            r_next.st = RSRX_ST_HOLD;
            case (r_reg.kind)
               RSRX_K_CCF: fl[`RSRX_FLAG_C] = 1'b0;
               RSRX_K_SB0: fl[`RSRX_FLAG_BANK] = 1'b0;
               RSRX_K_SB1: fl[`RSRX_FLAG_BANK] = 1'b1;
               RSRX_K_RET: begin
                  r_next.pc = {r_reg.src_val, cur_dst};
                  r_next.sp = r_reg.sp + 16'h0002;
               end
               RSRX_K_SBC: begin
                  sub9 = {1'b0, cur_dst} - {1'b0, r_reg.src_val} -
                     {8'h00, r_reg.flags[`RSRX_FLAG_C]};
                  low5 = {1'b0, cur_dst[3:0]} - {1'b0, r_reg.src_val[3:0]} -
                     {4'h0, r_reg.flags[`RSRX_FLAG_C]};
                  res = sub9[7:0];
                  mem_bus.we = 1'b1;
                  mem_bus.wdata = res;
                  fl[`RSRX_FLAG_C] = sub9[8];
                  fl[`RSRX_FLAG_Z] = (res == 8'h00);
                  fl[`RSRX_FLAG_S] = res[7];
                  fl[`RSRX_FLAG_V] = (cur_dst[7] != r_reg.src_val[7]) &&
                     (res[7] == r_reg.src_val[7]);
                  fl[`RSRX_FLAG_D] = 1'b1;
                  fl[`RSRX_FLAG_H] = low5[4];
               end
               default: begin
                  is_rot = 1'b1;
                  // rotate left and carry from bit 7
                  if (r_reg.kind == RSRX_K_RL) begin
                     res = {cur_dst[6:0], cur_dst[7]};
                     fl[`RSRX_FLAG_C] = cur_dst[7];
                  end else if (r_reg.kind == RSRX_K_RLC) begin
                     res = {cur_dst[6:0], r_reg.flags[`RSRX_FLAG_C]};
                     fl[`RSRX_FLAG_C] = cur_dst[7];
                  // rotate right and carry from bit 0
                  end else if (r_reg.kind == RSRX_K_RR) begin
                     res = {cur_dst[0], cur_dst[7:1]};
                     fl[`RSRX_FLAG_C] = cur_dst[0];
                  end else begin
                     res = {r_reg.flags[`RSRX_FLAG_C], cur_dst[7:1]};
                     fl[`RSRX_FLAG_C] = cur_dst[0];
                  end
                  mem_bus.we = 1'b1;
                  mem_bus.wdata = res;
                  // zero and sign from the result
                  fl[`RSRX_FLAG_Z] = (res == 8'h00);
                  fl[`RSRX_FLAG_S] = res[7];
                  fl[`RSRX_FLAG_V] = res[7] ^ cur_dst[7];
               end
            endcase
            r_next.flags = fl;
         end
         // pad to the documented cycle count
         RSRX_ST_HOLD: begin
            if (r_reg.cnt == r_reg.ncyc) begin
               r_next.st = RSRX_ST_IDLE;
               r_next.busy = 1'b0;
               r_next.done = 1'b1;
            end
         end
         default: begin
            r_next.st = RSRX_ST_IDLE;
            r_next.busy = 1'b0;
         end
      endcase
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r_reg <= '0;
         r_reg.flags <= `RSRX_FLAGS_RST;
         r_reg.pc <= `RSRX_PC_RST;
         r_reg.sp <= `RSRX_SP_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the state register, debug data from the register file read register
   assign o_flags = r_reg.flags;
   assign o_pc = r_reg.pc;
   assign o_sp = r_reg.sp;
   assign o_busy = r_reg.busy;
   assign o_done = r_reg.done;
   assign o_illegal = r_reg.illegal;
   assign o_dbg_data = mem_bus.dbg_data;

   // checks on timing and flag results
   logic acc;
   logic exec_rot;
   logic exec_sbc;
   logic exec_ret;
   logic [7:0] old_dst;
   logic [7:0] new_val;
   logic sbc_borrow;
   assign acc = (r_reg.st == RSRX_ST_IDLE) && (r_next.st != RSRX_ST_IDLE);
   assign exec_rot = (r_reg.st == RSRX_ST_EXEC) && is_rot;
   assign exec_sbc = (r_reg.st == RSRX_ST_EXEC) && (r_reg.kind == RSRX_K_SBC);
   assign exec_ret = (r_reg.st == RSRX_ST_EXEC) && (r_reg.kind == RSRX_K_RET);
   assign old_dst = cur_dst;
   assign new_val = res;
   assign sbc_borrow = sub9[8];

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);

   sequence seq_finish;
      !o_busy && o_done;
   endsequence
   sequence seq_busy4;
      o_busy [*4];
   endsequence

   chk_clear_carry_time: assert property (
      (acc && i_opcode == `RSRX_OP_CLR_CARRY) |=> seq_busy4 ##1 seq_finish)
      else $error("carry clear not four cycles");
   chk_clear_carry_flag: assert property (
      (acc && i_opcode == `RSRX_OP_CLR_CARRY) |-> ##2
      (!o_flags[`RSRX_FLAG_C] && o_flags[6:0] == $past(o_flags[6:0], 2)))
      else $error("carry clear changed wrong flags");
   chk_return_time: assert property (
      (acc && i_opcode == `RSRX_OP_RETURN) |=> o_busy [*8] ##1 seq_finish)
      else $error("return not eight cycles");
   chk_return_stack: assert property (
      exec_ret |=> (o_sp == $past(o_sp) + 16'h0002) &&
      (o_pc == {$past(r_reg.src_val), $past(old_dst)}) &&
      (o_flags == $past(o_flags)))
      else $error("return pc or sp wrong");
   chk_bank_high: assert property (
      (acc && i_opcode == `RSRX_OP_BANK1) |-> ##2
      (o_flags[0] && o_flags[7:1] == $past(o_flags[7:1], 2)))
      else $error("bank 1 select wrong");
   chk_bank_low: assert property (
      (acc && i_opcode == `RSRX_OP_BANK0) |=> seq_busy4 ##1
      (seq_finish and !o_flags[0]))
      else $error("bank 0 select wrong");
   chk_rot_flags: assert property (
      exec_rot |=> (o_flags[`RSRX_FLAG_Z] == ($past(new_val) == 8'h00)) &&
      (o_flags[`RSRX_FLAG_S] == $past(new_val[7])) &&
      (o_flags[3:0] == $past(o_flags[3:0])))
      else $error("rotate zero or sign wrong");
   chk_rot_overflow: assert property (
      exec_rot |=> o_flags[`RSRX_FLAG_V] ==
      ($past(new_val[7]) != $past(old_dst[7])))
      else $error("rotate overflow wrong");
   chk_sbc_flags: assert property (
      exec_sbc |=> o_flags[`RSRX_FLAG_D] &&
      (o_flags[`RSRX_FLAG_C] == $past(sbc_borrow)))
      else $error("sbc carry or decimal flag wrong");
   chk_sbc_ind_time: assert property (
      (acc && i_opcode == `RSRX_OP_SBC_RIR) |=> o_busy [*6] ##1 seq_finish)
      else $error("indirect sbc not six cycles");
   chk_done_pulse: assert property (
      o_done |=> !o_done)
      else $error("done longer than one cycle");
endmodule

// ==== test/rsrx_exec_top_test.sv ====
// rsrx_exec_top_test: self-checking bench for the execution slice
// assumes: design sources and rsrx_map.svh compiled first
`timescale 1ns/1ps
`include "rsrx_map.svh"
module rsrx_exec_top_test;
   logic clk, rst_n, start, ctx_ld, ld_en, busy, done, ill;
   logic [7:0] op, b1, b2, wbase, ctx_fl, ld_a, ld_d, dbg_a, dbg_d, flags;
   logic [15:0] ctx_pc, ctx_sp, pc, sp;
   int n_errors = 0;
   int n_compared = 0;

   rsrx_exec_top i_dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_start(start),
      .i_opcode(op), .i_byte1(b1), .i_byte2(b2), .i_work_base(wbase),
      .i_ctx_load(ctx_ld), .i_ctx_pc(ctx_pc), .i_ctx_sp(ctx_sp),
      .i_ctx_flags(ctx_fl), .i_load_en(ld_en), .i_load_addr(ld_a),
      .i_load_data(ld_d), .i_dbg_addr(dbg_a), .o_dbg_data(dbg_d),
      .o_flags(flags), .o_pc(pc), .o_sp(sp), .o_busy(busy), .o_done(done),
      .o_illegal(ill));

   // 25 MHz cpu clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // verdict and end of run
   task automatic wrap_up();
      if (n_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // compare seen against expected
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // one register file preload write
   task automatic ld(input logic [7:0] a, d);
      @(posedge clk) begin
         ld_en <= 1'b1;
         ld_a <= a;
         ld_d <= d;
      end
      @(posedge clk) ld_en <= 1'b0;
   endtask

   // context load of pc, sp and flags
   task automatic ctx(input logic [15:0] p, s, input logic [7:0] f);
      @(posedge clk) begin
         ctx_ld <= 1'b1;
         ctx_pc <= p;
         ctx_sp <= s;
         ctx_fl <= f;
      end
      @(posedge clk) ctx_ld <= 1'b0;
   endtask

   // register file peek, registered read
   task automatic peek(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk) dbg_a <= a;
      @(posedge clk);
      @(posedge clk);
      #1 d = dbg_d;
   endtask

   // issue one instruction, count busy cycles up to the done pulse
   task automatic run(input logic [7:0] o, x, y, input int n);
      int k;
      int cnt;
      cnt = 0;
      @(posedge clk) begin
         start <= 1'b1;
         op <= o;
         b1 <= x;
         b2 <= y;
      end
      @(posedge clk) start <= 1'b0;
      for (k = 0; k < 20; k++) begin
         #1;
         if (done === 1'b1) break;
         if (busy === 1'b1) cnt++;
         @(posedge clk);
      end
      if (k == 20) begin
         n_errors++;
         wrap_up();
      end
      chk("busy cycles", 16'(cnt), 16'(n));
      @(posedge clk);
      #1 chk("done width", done, 1'b0);
   endtask

   // all four rotates, register and indirect forms
   task automatic rotates();
      logic [7:0] ops [8] = '{8'h90, 8'h91, 8'h10, 8'h11,
         8'hE0, 8'hF1, 8'hC0, 8'hC1};
      logic [7:0] vals [4] = '{8'hAA, 8'h00, 8'h31, 8'h55};
      logic [7:0] v, r, got;
      logic c, nc;
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 4; j++) begin
            v = vals[j];
            c = j[0];
            case (i / 2)
               0: begin r = {v[6:0], v[7]}; nc = v[7]; end
               1: begin r = {v[6:0], c}; nc = v[7]; end
               2: begin r = {v[0], v[7:1]}; nc = v[0]; end
               default: begin r = {c, v[7:1]}; nc = v[0]; end
            endcase
            ctx(16'h0000, 16'h0000, {c, 7'h0D});
            ld(8'h20, v);
            ld(8'h21, 8'h22);
            ld(8'h22, v);
            run(ops[i], i[0] ? 8'h21 : 8'h20, 8'h00, 4);
            peek(i[0] ? 8'h22 : 8'h20, got);
            chk("rot result", got, r);
            chk("rot flags", flags,
               {nc, r == 8'h00, r[7], r[7] ^ v[7], 4'hD});
            peek(8'h21, got);
            chk("rot pointer", got, 8'h22);
         end
      end
   endtask

   // one subtract with carry, result and flags
   task automatic subtract_borrow_op(input logic [7:0] o, x, y, input logic cin,
      input logic [7:0] dst, res, fl, input int n);
      logic [7:0] got;
      ctx(16'h0000, 16'h0000, {cin, 7'h01});
      run(o, x, y, n);
      peek(dst, got);
      chk("sbc result", got, res);
      chk("sbc flags", flags, fl);
   endtask

   // carry clear, bank select, return, unsupported opcode
   task automatic misc();
      ctx(16'h1234, 16'h00FC, 8'hFF);
      run(`RSRX_OP_CLR_CARRY, 8'h00, 8'h00, 4);
      chk("clr carry", flags, 8'h7F);
      run(`RSRX_OP_BANK0, 8'h00, 8'h00, 4);
      chk("bank0", flags, 8'h7E);
      run(`RSRX_OP_BANK1, 8'h00, 8'h00, 4);
      chk("bank1", flags, 8'h7F);
      ld(8'hFC, 8'h10);
      ld(8'hFD, 8'h1A);
      ctx(16'h1234, 16'h00FC, 8'h5A);
      run(`RSRX_OP_RETURN, 8'h00, 8'h00, 8);
      chk("ret pc", pc, 16'h101A);
      chk("ret sp", sp, 16'h00FE);
      chk("ret flags", flags, 8'h5A);
      @(posedge clk) begin
         start <= 1'b1;
         op <= 8'h00;
      end
      @(posedge clk) start <= 1'b0;
      #1 chk("illegal", {ill, busy}, 2'b10);
   endtask

   // main sequence
   initial begin
      {start, ctx_ld, ld_en, op, b1, b2, ctx_fl, ld_a, ld_d, dbg_a} = '0;
      {ctx_pc, ctx_sp} = '0;
      wbase = 8'h30;
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk("reset", {flags, pc[7:0]}, 16'h0000);
      misc();
      rotates();
      ld(8'h31, 8'h10);
      ld(8'h32, 8'h03);
      subtract_borrow_op(8'h32, 8'h12, 8'h00, 1'b1, 8'h31, 8'h0C, 8'h0D, 4);
      peek(8'h32, ld_d);
      chk("sbc src kept", ld_d, 8'h03);
      ld(8'h31, 8'h10);
      ld(8'h03, 8'h0A);
      subtract_borrow_op(8'h33, 8'h12, 8'h00, 1'b1, 8'h31, 8'h05, 8'h0D, 6);
      ld(8'h42, 8'h43);
      ld(8'h43, 8'h0A);
      ld(8'h40, 8'h20);
      subtract_borrow_op(8'h35, 8'h42, 8'h40, 1'b1, 8'h40, 8'h15, 8'h0D, 6);
      ld(8'h44, 8'hFF);
      ld(8'h45, 8'h00);
      subtract_borrow_op(8'h34, 8'h44, 8'h45, 1'b0, 8'h45, 8'h01, 8'h8D, 6);
      ld(8'h46, 8'h20);
      subtract_borrow_op(8'h36, 8'h46, 8'h8A, 1'b1, 8'h46, 8'h95, 8'hBD, 6);
      ld(8'h47, 8'h55);
      subtract_borrow_op(8'h36, 8'h47, 8'h55, 1'b0, 8'h47, 8'h00, 8'h49, 6);
      wrap_up();
   end
endmodule
